// ===== osm_defines.svh
// Constants of the oscillator mode and clock-path selector.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef OSM_DEFINES_SVH
`define OSM_DEFINES_SVH

// ****************************************************************
// Oscillator selection field encodings
// ****************************************************************
`define OSM_CFG_W 4
`define OSM_CODE_LP 4'h0
`define OSM_CODE_XT 4'h1
`define OSM_CODE_HS 4'h2
`define OSM_CODE_RC 4'h3
`define OSM_CODE_EC 4'h4
`define OSM_CODE_ECIO 4'h5
`define OSM_CODE_XPLL 4'h6
`define OSM_CODE_RESISTOR_CAP_GPIO_MODE 4'h7
`define OSM_CODE_INTIO 4'h8
`define OSM_CODE_INTCK 4'h9

// ****************************************************************
// Clock figures
// ****************************************************************
`define OSM_CLKOUT_DIV 4
`define OSM_PLL_MULT 4
`define OSM_XTAL_MAX_MHZ 10
`define OSM_XPLL_MAX_MHZ 40
`define OSM_INTPLL_MAX_MHZ 32
`define OSM_MHZ_W 6
`define OSM_PIN6 6
`define OSM_PIN7 7

`endif

// ===== osm_pkg.sv
// Types of the oscillator mode and clock-path selector.
// Assumes osm_defines.svh is on the include path.
`include "osm_defines.svh"

package osm_pkg;

    // ************************************************************
    // Oscillator modes
    // ************************************************************
    typedef enum logic [3:0] {
        OSM_MODE_LP = `OSM_CODE_LP,
        OSM_MODE_XT = `OSM_CODE_XT,
        OSM_MODE_HS = `OSM_CODE_HS,
        OSM_MODE_RC = `OSM_CODE_RC,
        OSM_MODE_EC = `OSM_CODE_EC,
        OSM_MODE_ECIO = `OSM_CODE_ECIO,
        OSM_MODE_XPLL = `OSM_CODE_XPLL,
        OSM_MODE_RESISTOR_CAP_GPIO_MODE = `OSM_CODE_RESISTOR_CAP_GPIO_MODE,
        OSM_MODE_INTIO = `OSM_CODE_INTIO,
        OSM_MODE_INTCK = `OSM_CODE_INTCK
    } osm_mode_t;

    // ************************************************************
    // Pin and clock-path roles of one mode
    // ************************************************************
    typedef struct packed {
        logic pin6_clkout;
        logic pin6_gpio;
        logic pin7_gpio;
        logic pll_xtal;
        logic int_osc;
        logic rc_core;
    } osm_role_t;

endpackage

// ===== osm_role_if.sv
// Carrier between the mode register and the role decoder.
// Assumes osm_pkg is compiled first.
interface osm_role_if;
    import osm_pkg::*;
    osm_mode_t mode;
    osm_role_t role;
    modport src (output mode, input role);
    modport dec (input mode, output role);
endinterface

// ===== osm_role_decode.sv
// Static decode of the latched oscillator mode into pin and PLL roles.
// Assumes the mode on the carrier only changes at reset release.
module osm_role_decode
(
    osm_role_if.dec rif // Mode in, roles out
);
    import osm_pkg::*;

    // ************************************************************
    // Role table
    // ************************************************************
    always_comb
    begin
        rif.role = '0;
        unique case (rif.mode)
            OSM_MODE_RC:
            begin
                rif.role.rc_core = 1'b1;
                rif.role.pin6_clkout = 1'b1;
            end
            OSM_MODE_RESISTOR_CAP_GPIO_MODE:
            begin
                rif.role.rc_core = 1'b1;
                rif.role.pin6_gpio = 1'b1;
            end
            OSM_MODE_XPLL:
            begin
                rif.role.pll_xtal = 1'b1;
            end
            OSM_MODE_ECIO:
            begin
                rif.role.pin6_gpio = 1'b1;
            end
            OSM_MODE_INTIO:
            begin
                rif.role.int_osc = 1'b1;
                rif.role.pin6_gpio = 1'b1;
                rif.role.pin7_gpio = 1'b1;
            end
            OSM_MODE_INTCK:
            begin
                rif.role.int_osc = 1'b1;
                rif.role.pin6_clkout = 1'b1;
                rif.role.pin7_gpio = 1'b1;
            end
            default:
            begin
                rif.role = '0;
            end
        endcase
    end

endmodule

// ===== osm_select.sv
// Oscillator mode selector: pin roles of the second oscillator pin and
// port A bits 6 and 7, the quarter-rate clock output (RC mode only; INTCK drives pin 6 low) and the PLL path.
// Assumes the oscillator level is at most a quarter of i_clock, and
// that the configuration field is stable across reset release.
`include "osm_defines.svh"

module osm_select
(
    input wire logic i_clock, // 50 MHz system clock
    input wire logic i_rst, // Synchronous reset, active high
    input wire logic [`OSM_CFG_W-1:0] i_osc_select_config, // Oscillator selection field
    input wire logic i_osc_level, // Oscillator level seen at the first pin
    input wire logic i_pll_sw_enable, // Software PLL enable
    input wire logic i_port_a_pin6_in, // Second oscillator pin level
    input wire logic i_port_a_pin7_in, // First oscillator pin level as I/O
    input wire logic [1:0] i_lat_hi, // Latch bits 7:6 written by the core
    input wire logic [1:0] i_tris_hi, // Direction bits 7:6, high is input
    output logic o_second_osc_pin_out, // Second oscillator pin drive value
    output logic o_second_osc_pin_oe, // Second oscillator pin drive enable
    output logic o_port_a_pin7_out, // First oscillator pin drive value
    output logic o_port_a_pin7_oe, // First oscillator pin drive enable
    output logic [1:0] o_port_a_pins_rd, // Port A bits 7:6 read value
    output logic [1:0] o_lat_rd, // Latch bits 7:6 read value
    output logic [1:0] o_tris_rd, // Direction bits 7:6 read value
    output logic o_pll_on, // PLL running
    output logic o_pll_src_int, // PLL fed by the internal oscillator
    output logic o_rc_core_on, // Resistor-capacitor oscillator core active
    output logic [`OSM_MHZ_W-1:0] o_max_clock_mhz, // Highest internal clock allowed
    output osm_pkg::osm_mode_t o_mode // Latched oscillator mode
);
    import osm_pkg::*;

    // ************************************************************
    // Declarations
    // ************************************************************
    localparam logic [`OSM_MHZ_W-1:0] XTAL_MHZ = `OSM_MHZ_W'(`OSM_XTAL_MAX_MHZ);
    localparam logic [`OSM_MHZ_W-1:0] XPLL_MHZ = `OSM_MHZ_W'(`OSM_XPLL_MAX_MHZ);
    localparam logic [`OSM_MHZ_W-1:0] INTPLL_MHZ = `OSM_MHZ_W'(`OSM_INTPLL_MAX_MHZ);
    localparam logic [`OSM_MHZ_W-1:0] PLL_OUT_MHZ =
        `OSM_MHZ_W'(`OSM_XTAL_MAX_MHZ * `OSM_PLL_MULT);
    localparam int HALF_DIV = `OSM_CLKOUT_DIV / 2;
    localparam logic [1:0] HALF_LAST = 2'(HALF_DIV - 1);

    osm_role_if rif ();

    osm_mode_t mode_ff;
    osm_mode_t nxt_mode;
    logic taken_ff;
    logic nxt_taken;
    logic [2:0] sync1_ff;
    logic [2:0] sync2_ff;
    logic osc_prev_ff;
    logic nxt_osc_prev;
    logic [1:0] div_cnt_ff;
    logic [1:0] nxt_div_cnt;
    logic clkout_ff;
    logic nxt_clkout;
    logic pin6_out_ff;
    logic nxt_pin6_out;
    logic pin6_oe_ff;
    logic nxt_pin6_oe;
    logic pin7_out_ff;
    logic nxt_pin7_out;
    logic pin7_oe_ff;
    logic nxt_pin7_oe;
    logic [1:0] port_rd_ff;
    logic [1:0] nxt_port_rd;
    logic [1:0] lat_rd_ff;
    logic [1:0] nxt_lat_rd;
    logic [1:0] tris_rd_ff;
    logic [1:0] nxt_tris_rd;
    logic pll_on_ff;
    logic nxt_pll_on;
    logic pll_int_ff;
    logic nxt_pll_int;
    logic rc_on_ff;
    logic nxt_rc_on;
    logic [`OSM_MHZ_W-1:0] mhz_ff;
    logic [`OSM_MHZ_W-1:0] nxt_mhz;
    logic [1:0] bit_en;
    logic [1:0] pin_sync;

    assign rif.mode = mode_ff;

    osm_role_decode u_decode (
        .rif (rif)
    );

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            sync1_ff <= 3'h0;
            sync2_ff <= 3'h0;
        end
        else
        begin
            sync1_ff <= {i_port_a_pin7_in, i_port_a_pin6_in, i_osc_level};
            sync2_ff <= sync1_ff;
        end
    end

    assign pin_sync = sync2_ff[2:1];

    // ************************************************************
    // Mode latch, taken once after reset release
    // ************************************************************
    always_comb
    begin
        nxt_mode = mode_ff;
        nxt_taken = 1'b1;
        if (!taken_ff)
        begin
            nxt_mode = osm_mode_t'(i_osc_select_config);
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            mode_ff <= OSM_MODE_LP;
            taken_ff <= 1'b0;
        end
        else
        begin
            mode_ff <= nxt_mode;
            taken_ff <= nxt_taken;
        end
    end

    // ************************************************************
    // Quarter-rate clock from the resistor-capacitor oscillator
    // ************************************************************
    always_comb
    begin
        nxt_osc_prev = sync2_ff[0];
        nxt_div_cnt = div_cnt_ff;
        nxt_clkout = clkout_ff;
        if (!rif.role.rc_core)
        begin
            nxt_div_cnt = 2'h0;
            nxt_clkout = 1'b0;
        end
        else if (sync2_ff[0] && !osc_prev_ff)
        begin
            if (div_cnt_ff == HALF_LAST)
            begin
                nxt_div_cnt = 2'h0;
                nxt_clkout = !clkout_ff;
            end
            else
            begin
                nxt_div_cnt = div_cnt_ff + 2'h1;
            end
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            osc_prev_ff <= 1'b0;
            div_cnt_ff <= 2'h0;
            clkout_ff <= 1'b0;
        end
        else
        begin
            osc_prev_ff <= nxt_osc_prev;
            div_cnt_ff <= nxt_div_cnt;
            clkout_ff <= nxt_clkout;
        end
    end

    // ************************************************************
    // Pin roles, gated port bits and PLL path
    // ************************************************************
    assign bit_en = {rif.role.pin7_gpio, rif.role.pin6_gpio};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_bit
            always_comb
            begin
                nxt_port_rd[gi] = bit_en[gi] && pin_sync[gi];
                nxt_lat_rd[gi] = bit_en[gi] && i_lat_hi[gi];
                nxt_tris_rd[gi] = bit_en[gi] && i_tris_hi[gi];
            end
        end
    endgenerate

    always_comb
    begin
        nxt_pin6_out = 1'b0;
        nxt_pin6_oe = 1'b0;
        if (rif.role.pin6_clkout)
        begin
            nxt_pin6_out = rif.role.rc_core ? clkout_ff : 1'b0;
            nxt_pin6_oe = 1'b1;
        end
        else if (rif.role.pin6_gpio)
        begin
            nxt_pin6_out = i_lat_hi[0];
            nxt_pin6_oe = !i_tris_hi[0];
        end
        nxt_pin7_out = rif.role.pin7_gpio && i_lat_hi[1];
        nxt_pin7_oe = rif.role.pin7_gpio && !i_tris_hi[1];
        nxt_rc_on = rif.role.rc_core;
        nxt_pll_int = rif.role.int_osc && i_pll_sw_enable;
        nxt_pll_on = rif.role.pll_xtal || nxt_pll_int;
        if (rif.role.pll_xtal)
        begin
            nxt_mhz = (PLL_OUT_MHZ < XPLL_MHZ) ? PLL_OUT_MHZ : XPLL_MHZ;
        end
        else if (nxt_pll_int)
        begin
            nxt_mhz = INTPLL_MHZ;
        end
        else
        begin
            nxt_mhz = XTAL_MHZ;
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            pin6_out_ff <= 1'b0;
            pin6_oe_ff <= 1'b0;
            pin7_out_ff <= 1'b0;
            pin7_oe_ff <= 1'b0;
            port_rd_ff <= 2'h0;
            lat_rd_ff <= 2'h0;
            tris_rd_ff <= 2'h0;
            pll_on_ff <= 1'b0;
            pll_int_ff <= 1'b0;
            rc_on_ff <= 1'b0;
            mhz_ff <= '0;
        end
        else
        begin
            pin6_out_ff <= nxt_pin6_out;
            pin6_oe_ff <= nxt_pin6_oe;
            pin7_out_ff <= nxt_pin7_out;
            pin7_oe_ff <= nxt_pin7_oe;
            port_rd_ff <= nxt_port_rd;
            lat_rd_ff <= nxt_lat_rd;
            tris_rd_ff <= nxt_tris_rd;
            pll_on_ff <= nxt_pll_on;
            pll_int_ff <= nxt_pll_int;
            rc_on_ff <= nxt_rc_on;
            mhz_ff <= nxt_mhz;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign o_second_osc_pin_out = pin6_out_ff;
    assign o_second_osc_pin_oe = pin6_oe_ff;
    assign o_port_a_pin7_out = pin7_out_ff;
    assign o_port_a_pin7_oe = pin7_oe_ff;
    assign o_port_a_pins_rd = port_rd_ff;
    assign o_lat_rd = lat_rd_ff;
    assign o_tris_rd = tris_rd_ff;
    assign o_pll_on = pll_on_ff;
    assign o_pll_src_int = pll_int_ff;
    assign o_rc_core_on = rc_on_ff;
    assign o_max_clock_mhz = mhz_ff;
    assign o_mode = mode_ff;

endmodule

// ===== osm_checker.sv
// Assertions on the ports of the oscillator mode selector.
// Assumes a bind to osm_select, one clock, synchronous active-high reset.
module osm_checker
(
    input wire logic i_clock, // Clock
    input wire logic i_rst, // Reset
    input wire logic [3:0] i_osc_select_config, // Mode field
    input wire logic i_osc_level, // Oscillator
    input wire logic i_pll_sw_enable, // PLL enable
    input wire logic i_port_a_pin6_in, // Pin 6 level
    input wire logic i_port_a_pin7_in, // Pin 7 level
    input wire logic [1:0] i_lat_hi, // Latch bits
    input wire logic [1:0] i_tris_hi, // Direction bits
    input wire logic o_second_osc_pin_out, // Pin 6 value
    input wire logic o_second_osc_pin_oe, // Pin 6 enable
    input wire logic o_port_a_pin7_out, // Pin 7 value
    input wire logic o_port_a_pin7_oe, // Pin 7 enable
    input wire logic [1:0] o_port_a_pins_rd, // Port read
    input wire logic [1:0] o_lat_rd, // Latch read
    input wire logic [1:0] o_tris_rd, // Direction read
    input wire logic o_pll_on, // PLL on
    input wire logic o_pll_src_int, // PLL internal
    input wire logic o_rc_core_on, // RC core
    input wire logic [5:0] o_max_clock_mhz, // Clock ceiling
    input wire osm_pkg::osm_mode_t o_mode // Latched mode
);
    timeunit 1ns;
    timeprecision 1ps;
    import osm_pkg::*;
    // ************************************************************
    // Roles are valid two edges after reset release
    // ************************************************************
    logic [1:0] run_ff;
    logic [1:0] nxt_run;
    logic ready;
    always_comb
    begin
        nxt_run = (run_ff == 2'h3) ? run_ff : run_ff + 2'h1;
        if (i_rst)
        begin
            nxt_run = 2'h0;
        end
    end
    always_ff @(posedge i_clock)
    begin
        run_ff <= nxt_run;
    end
    assign ready = run_ff[1];
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);

    // ************************************************************
    // Properties
    // ************************************************************
    xpll_path_a: assert property (ready && o_mode == OSM_MODE_XPLL |-> o_pll_on
        && !o_pll_src_int && o_max_clock_mhz == 6'h28) else $error("crystal PLL path wrong");
    pll_only_a: assert property (ready && !(o_mode inside {OSM_MODE_XPLL,
        OSM_MODE_INTIO, OSM_MODE_INTCK}) |-> !o_pll_on) else $error("PLL on in plain mode");
    int_pll_a: assert property (ready && o_mode inside {OSM_MODE_INTIO, OSM_MODE_INTCK}
        && $past(i_pll_sw_enable) |-> o_pll_on && o_pll_src_int && o_max_clock_mhz == 6'h20)
        else $error("internal PLL not on");
    mode_hold_a: assert property (ready |-> $stable(o_mode)) else $error("mode moved");
    rc_core_a: assert property (ready |-> o_rc_core_on ==
        (o_mode inside {OSM_MODE_RC, OSM_MODE_RESISTOR_CAP_GPIO_MODE})) else $error("RC core wrong");
    clkout_oe_a: assert property (ready && o_mode == OSM_MODE_RC |-> o_second_osc_pin_oe
        && o_lat_rd == 2'h0) else $error("clock pin not driven");
    resistor_cap_gpio_mode_pin6_a: assert property (ready && o_mode == OSM_MODE_RESISTOR_CAP_GPIO_MODE |->
        o_lat_rd == ($past(i_lat_hi) & 2'h1) && o_second_osc_pin_oe == ~|($past(i_tris_hi)
        & 2'h1)) else $error("pin 6 port wrong");
    disabled_zero_a: assert property (ready && o_mode inside {OSM_MODE_LP, OSM_MODE_HS,
        OSM_MODE_XPLL} |-> o_tris_rd == 2'h0 ##1 o_port_a_pins_rd == 2'h0)
        else $error("disabled bits not zero");
    cover property (ready && o_pll_on && o_pll_src_int);
    cover property (ready && o_mode == OSM_MODE_RC && $changed(o_second_osc_pin_out));
    cover property (ready && o_mode == OSM_MODE_INTIO && o_port_a_pin7_oe);
endmodule

// ===== osm_select_bench.sv
// Self-checking bench of the oscillator mode selector.
// Assumes osm_pkg, osm_role_if, osm_role_decode and osm_select compiled first.
module osm_select_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import osm_pkg::*;
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    logic [3:0] i_osc_select_config = 4'h0;
    logic i_osc_level = 1'b0;
    logic i_pll_sw_enable = 1'b0;
    logic i_port_a_pin6_in = 1'b0;
    logic i_port_a_pin7_in = 1'b0;
    logic [1:0] i_lat_hi = 2'h0;
    logic [1:0] i_tris_hi = 2'h3;
    logic o_second_osc_pin_out, o_second_osc_pin_oe, o_port_a_pin7_out, o_port_a_pin7_oe;
    logic [1:0] o_port_a_pins_rd, o_lat_rd, o_tris_rd;
    logic o_pll_on, o_pll_src_int, o_rc_core_on;
    logic [5:0] o_max_clock_mhz;
    osm_mode_t o_mode;
    logic [2:0] osc_cnt = 3'h0;
    int seed = 50;
    int err_total = 0;
    int n_checks = 0;
    int cycles = 0;
    int m;

    osm_select osm_select_inst (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_osc_select_config(i_osc_select_config),
        .i_osc_level(i_osc_level),
        .i_pll_sw_enable(i_pll_sw_enable),
        .i_port_a_pin6_in(i_port_a_pin6_in),
        .i_port_a_pin7_in(i_port_a_pin7_in),
        .i_lat_hi(i_lat_hi),
        .i_tris_hi(i_tris_hi),
        .o_second_osc_pin_out(o_second_osc_pin_out),
        .o_second_osc_pin_oe(o_second_osc_pin_oe),
        .o_port_a_pin7_out(o_port_a_pin7_out),
        .o_port_a_pin7_oe(o_port_a_pin7_oe),
        .o_port_a_pins_rd(o_port_a_pins_rd),
        .o_lat_rd(o_lat_rd),
        .o_tris_rd(o_tris_rd),
        .o_pll_on(o_pll_on),
        .o_pll_src_int(o_pll_src_int),
        .o_rc_core_on(o_rc_core_on),
        .o_max_clock_mhz(o_max_clock_mhz),
        .o_mode(o_mode)
    );

    // ************************************************************
    // Clock, oscillator of 8 clock periods, hang limit
    // ************************************************************
    always #10 i_clock = ~i_clock;
    always @(posedge i_clock)
    begin
        osc_cnt <= osc_cnt + 3'h1;
        i_osc_level <= osc_cnt[2];
        cycles++;
        if (cycles == 20000)
        begin
            err_total++;
            print_verdict();
        end
    end

    // ************************************************************
    // Expectations and checks
    // ************************************************************
    function automatic logic [1:0] exp_en(input logic [3:0] c);
        case (c)
            OSM_MODE_ECIO, OSM_MODE_RESISTOR_CAP_GPIO_MODE: exp_en = 2'h1;
            OSM_MODE_INTIO: exp_en = 2'h3;
            OSM_MODE_INTCK: exp_en = 2'h2;
            default: exp_en = 2'h0;
        endcase
    endfunction
    function automatic logic exp_pll(input logic [3:0] c, input logic pe);
        exp_pll = (c == OSM_MODE_XPLL) || (pe && c inside {OSM_MODE_INTIO, OSM_MODE_INTCK});
    endfunction
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH %s expected %0h seen %0h", name, exp, got);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ************************************************************
    // One mode: latch, random port traffic, clock pin
    // ************************************************************
    task automatic run_mode(input logic [3:0] c);
        logic [1:0] en;
        logic [31:0] r;
        logic [7:0] mhz;
        logic prev;
        int k;
        int gap;
        en = exp_en(c);
        @(posedge i_clock);
        i_rst <= 1'b1;
        i_osc_select_config <= c;
        repeat (8) @(posedge i_clock);
        i_rst <= 1'b0;
        @(posedge i_clock);
        i_osc_select_config <= ~c;
        repeat (3) @(negedge i_clock);
        chk("mode", 8'(c), 8'(o_mode));
        for (k = 0; k < 12; k++)
        begin
            @(posedge i_clock);
            r = $random(seed);
            i_lat_hi <= r[1:0];
            i_tris_hi <= r[3:2];
            {i_port_a_pin7_in, i_port_a_pin6_in} <= r[5:4];
            i_pll_sw_enable <= r[6];
            repeat (5) @(negedge i_clock);
            mhz = (c == OSM_MODE_XPLL) ? 8'h28 : (exp_pll(c, r[6]) ? 8'h20 : 8'h0a);
            chk("lat_rd", 8'(r[1:0] & en), 8'(o_lat_rd));
            chk("tris_rd", 8'(r[3:2] & en), 8'(o_tris_rd));
            chk("pins_rd", 8'(r[5:4] & en), 8'(o_port_a_pins_rd));
            chk("pll_on", 8'(exp_pll(c, r[6])), 8'(o_pll_on));
            chk("pll_src", 8'(exp_pll(c, r[6]) && c != OSM_MODE_XPLL), 8'(o_pll_src_int));
            chk("max_mhz", mhz, 8'(o_max_clock_mhz));
            chk("rc_core", 8'(c inside {OSM_MODE_RC, OSM_MODE_RESISTOR_CAP_GPIO_MODE}), 8'(o_rc_core_on));
            chk("pin6_oe", 8'((c inside {OSM_MODE_RC, OSM_MODE_INTCK}) | (en[0] & ~r[2])),
                8'(o_second_osc_pin_oe));
            chk("pin7_oe", 8'(en[1] & ~r[3]), 8'(o_port_a_pin7_oe));
            if (en[1] & ~r[3])
                chk("pin7_out", 8'(r[1]), 8'(o_port_a_pin7_out));
            if (c == OSM_MODE_INTCK)
                chk("pin6_out", 8'h0, 8'(o_second_osc_pin_out));
            else if (en[0] & ~r[2])
                chk("pin6_out", 8'(r[0]), 8'(o_second_osc_pin_out));
        end
        if (c == OSM_MODE_RC)
        begin
            prev = o_second_osc_pin_out;
            for (k = 0; k < 200 && o_second_osc_pin_out === prev; k++)
                @(negedge i_clock);
            prev = o_second_osc_pin_out;
            for (gap = 0; gap < 200 && o_second_osc_pin_out === prev; gap++)
                @(negedge i_clock);
            chk("half_period", 8'h10, 8'(gap));
        end
        $display("test of mode %0h done", c);
    endtask

    initial
    begin
        // Codes 0 to 9 are the listed modes, code 10 an unlisted one
        for (m = 0; m < 11; m++)
        begin
            run_mode(4'(m));
        end
        print_verdict();
    end
endmodule

bind osm_select osm_checker osm_checker_inst (.i_clock(i_clock), .i_rst(i_rst),
    .i_osc_select_config(i_osc_select_config), .i_osc_level(i_osc_level),
    .i_pll_sw_enable(i_pll_sw_enable), .i_port_a_pin6_in(i_port_a_pin6_in),
    .i_port_a_pin7_in(i_port_a_pin7_in), .i_lat_hi(i_lat_hi), .i_tris_hi(i_tris_hi),
    .o_second_osc_pin_out(o_second_osc_pin_out), .o_second_osc_pin_oe(o_second_osc_pin_oe),
    .o_port_a_pin7_out(o_port_a_pin7_out), .o_port_a_pin7_oe(o_port_a_pin7_oe),
    .o_port_a_pins_rd(o_port_a_pins_rd), .o_lat_rd(o_lat_rd), .o_tris_rd(o_tris_rd),
    .o_pll_on(o_pll_on), .o_pll_src_int(o_pll_src_int), .o_rc_core_on(o_rc_core_on),
    .o_max_clock_mhz(o_max_clock_mhz), .o_mode(o_mode));
